// ==== hdl/fpf_filter.sv ====
// Frame pattern table and WAN protocol filter engine
//
// The plain strobed port and the register addresses were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module fpf_filter
    import fpf_pkg::*;
(
    input  wire logic                clk_i,
    input  wire logic                nrst_i,
    input  wire logic [7:0]          reg_addr_i,
    input  wire logic [15:0]         reg_wdata_i,
    input  wire logic                reg_wr_i,
    input  wire logic                reg_rd_i,
    output logic      [15:0]         reg_rdata_o,
    input  wire logic                lan_vld_i,
    input  wire logic                lan_sof_i,
    input  wire logic                lan_eof_i,
    input  wire logic [15:0]         lan_word_i,
    input  wire logic [2:0]          lan_sa_dst_i,
    output logic                     lan_done_o,
    output logic                     lan_to_cpu_o,
    output logic                     lan_to_wan_o,
    output logic                     lan_reject_o,
    input  wire logic                wan_start_i,
    input  wire logic                wan_ok_i,
    input  wire logic [15:0]         wan_proto_i,
    input  wire logic [47:0]         wan_da_i,
    output logic                     db_rd_o,
    output logic [HASH_W+2:0]        db_addr_o,
    input  wire logic                db_valid_i,
    input  wire logic [47:0]         db_addr_val_i,
    input  wire logic [2:0]          db_dst_i,
    output logic                     wan_done_o,
    output logic                     wan_to_lan_o,
    output logic                     wan_to_cpu_o,
    output logic                     wan_drop_o
);
    localparam int IX_W = $clog2(ENTRIES);

    if (ENTRIES > 32 || STRINGS != 8 || BKT_DEPTH != 8) begin : g_geom_chk
        $error("fpf_filter: unsupported table geometry");
    end

    typedef struct packed {
        logic [15:0]             rdata;
        logic [ENTRIES-1:0][15:0] ctl;
        logic [ENTRIES-1:0][15:0] val;
        logic [ENTRIES-1:0][15:0] msk;
        logic                    lan_en;
        logic                    wan_en;
        logic                    in_frame;
        logic [4:0]              wcnt;
        logic [IX_W:0]           idx;
        logic [STRINGS-1:0]      res;
        logic [1:0]              tbl_dst;
        logic                    tbl_hit;
        logic                    lan_done;
        logic                    lan_cpu;
        logic                    lan_wan;
        logic                    lan_rej;
        fpf_wstate_t             ws;
        logic [HASH_W-1:0]       hash;
        logic [2:0]              slot;
        logic                    db_rd;
        logic                    rd_pend;
        logic                    wan_done;
        logic                    wan_lan;
        logic                    wan_cpu;
        logic                    wan_drop;
    } fpf_state_t;

    fpf_state_t r_ff, nxt_r;
    logic [1:0] rst_sync_ff;
    logic       rst_n;
    assign rst_n = rst_sync_ff[1];

    // Reset synchroniser kept apart: only state with an async clear
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rst_sync_ff <= 2'h0;
        end else begin
            rst_sync_ff <= {rst_sync_ff[0], 1'b1};
        end
    end

    function automatic logic [HASH_W-1:0] hash_f(input logic [47:0] a);
        logic [HASH_W-1:0] h;
        h = '0;
        for (int n = 0; n < HASH_W; n++) begin
            for (int k = 0; k < 5; k++) begin
                if (n + 10 * k < ADDR_W)
                    h[n] = h[n] ^ a[n + 10 * k];
            end
        end
        return h;
    endfunction

    logic [15:0]   cur_ctl;
    logic [15:0]   masked;
    logic          cmp;
    logic [2:0]    sid;
    logic          ent_en;
    logic [4:0]    ent_ofs;
    logic [IX_W:0] tbl_i;

    always_comb begin
        nxt_r = r_ff;
        nxt_r.lan_done = 1'b0;
        nxt_r.wan_done = 1'b0;
        nxt_r.db_rd = 1'b0;
        cur_ctl = 16'h0000;
        ent_en = 1'b0;
        ent_ofs = 5'h00;
        masked = 16'h0000;
        cmp = 1'b0;
        sid = 3'h0;
        tbl_i = '0;

        // Register port
        nxt_r.rdata = 16'h0000;
        if (reg_rd_i) begin
            if (reg_addr_i == REG_CTRL)
                nxt_r.rdata = {14'h0, r_ff.wan_en, r_ff.lan_en};
            else if (reg_addr_i == REG_LSTAT)
                nxt_r.rdata = {r_ff.res, 3'h0, r_ff.in_frame,
                               r_ff.tbl_hit, 1'b0, r_ff.tbl_dst};
            else if (reg_addr_i == REG_WSTAT)
                nxt_r.rdata = {6'h0, r_ff.hash};
            else if (reg_addr_i >= REG_TBL && reg_addr_i < REG_TBL_END) begin
                tbl_i = (IX_W+1)'((reg_addr_i - REG_TBL) / 8'h03);
                case ((reg_addr_i - REG_TBL) % 8'h03)
                    8'h00:   nxt_r.rdata = r_ff.ctl[tbl_i];
                    8'h01:   nxt_r.rdata = r_ff.val[tbl_i];
                    default: nxt_r.rdata = r_ff.msk[tbl_i];
                endcase
            end
        end
        if (reg_wr_i) begin
            if (reg_addr_i == REG_CTRL) begin
                nxt_r.lan_en = reg_wdata_i[0];
                nxt_r.wan_en = reg_wdata_i[1];
            end else if (reg_addr_i >= REG_TBL
                         && reg_addr_i < REG_TBL_END) begin
                tbl_i = (IX_W+1)'((reg_addr_i - REG_TBL) / 8'h03);
                case ((reg_addr_i - REG_TBL) % 8'h03)
                    8'h00:   nxt_r.ctl[tbl_i] = reg_wdata_i;
                    8'h01:   nxt_r.val[tbl_i] = reg_wdata_i;
                    default: nxt_r.msk[tbl_i] = reg_wdata_i;
                endcase
            end
        end

        // LAN pattern table walk, at most one entry per clock
        if (lan_vld_i && r_ff.lan_en) begin
            if (lan_sof_i) begin
                nxt_r.wcnt = 5'h00;
                nxt_r.res = '0;
                nxt_r.idx = '0;
                nxt_r.in_frame = 1'b1;
                nxt_r.tbl_dst = DST_REJECT;
                nxt_r.tbl_hit = 1'b0;
            end else if (r_ff.in_frame && r_ff.wcnt != 5'h1f) begin
                nxt_r.wcnt = r_ff.wcnt + 5'h01;
            end
        end
        if (r_ff.in_frame && r_ff.idx < (IX_W+1)'(ENTRIES)) begin
            cur_ctl = r_ff.ctl[r_ff.idx[IX_W-1:0]];
            ent_en = cur_ctl[CW_EN];
            ent_ofs = cur_ctl[CW_OFS_HI:CW_OFS_LO];
            sid = cur_ctl[CW_STR_HI:CW_STR_LO];
            masked = lan_word_i & r_ff.msk[r_ff.idx[IX_W-1:0]];
            case (cur_ctl[CW_OP_HI:CW_OP_LO])
                OP_EQ:   cmp = masked == r_ff.val[r_ff.idx[IX_W-1:0]];
                OP_LT:   cmp = masked < r_ff.val[r_ff.idx[IX_W-1:0]];
                OP_GT:   cmp = masked > r_ff.val[r_ff.idx[IX_W-1:0]];
                default: cmp = 1'b0;
            endcase
            if (!ent_en) begin
                nxt_r.idx = r_ff.idx + 1'b1;
            end else if (lan_vld_i && !lan_sof_i
                         && ent_ofs == r_ff.wcnt + 5'h01) begin
                // Word for this entry arrives now (offset leads count)
                if (cur_ctl[CW_BEG])
                    nxt_r.res[sid] = cmp;
                else
                    nxt_r.res[sid] = r_ff.res[sid] & cmp;
                if (cur_ctl[CW_END]
                    && (cur_ctl[CW_BEG] ? cmp : r_ff.res[sid] & cmp)) begin
                    nxt_r.tbl_dst = cur_ctl[CW_DST_HI:CW_DST_LO];
                    nxt_r.tbl_hit = 1'b1;
                end
                nxt_r.idx = r_ff.idx + 1'b1;
            end else if (ent_ofs == 5'h00 && r_ff.wcnt == 5'h00
                         && lan_vld_i && lan_sof_i) begin
                nxt_r.idx = r_ff.idx;
            end else if (ent_ofs <= r_ff.wcnt) begin
                // Entry word already passed in this frame
                nxt_r.idx = r_ff.idx + 1'b1;
            end
        end
        // Entry 0, if at offset 0, compares against the first word itself
        if (lan_vld_i && lan_sof_i && r_ff.lan_en) begin
            cur_ctl = r_ff.ctl[0];
            masked = lan_word_i & r_ff.msk[0];
            case (cur_ctl[CW_OP_HI:CW_OP_LO])
                OP_EQ:   cmp = masked == r_ff.val[0];
                OP_LT:   cmp = masked < r_ff.val[0];
                OP_GT:   cmp = masked > r_ff.val[0];
                default: cmp = 1'b0;
            endcase
            if (cur_ctl[CW_EN] && cur_ctl[CW_OFS_HI:CW_OFS_LO] == 5'h00) begin
                nxt_r.res[cur_ctl[CW_STR_HI:CW_STR_LO]] = cmp;
                if (cur_ctl[CW_END] && cmp) begin
                    nxt_r.tbl_dst = cur_ctl[CW_DST_HI:CW_DST_LO];
                    nxt_r.tbl_hit = 1'b1;
                end
                nxt_r.idx = (IX_W+1)'(1);
            end
        end
        if (lan_vld_i && lan_eof_i && r_ff.in_frame) begin
            nxt_r.in_frame = 1'b0;
            nxt_r.lan_done = 1'b1;
            // Combine with address lookup; lookup 000 or table hit with 00 rejects
            nxt_r.lan_rej = (lan_sa_dst_i == SA_REJECT)
                            || (nxt_r.tbl_hit
                                && nxt_r.tbl_dst == DST_REJECT);
            nxt_r.lan_cpu = !nxt_r.lan_rej && (nxt_r.tbl_hit
                            ? nxt_r.tbl_dst[0] : lan_sa_dst_i[0]);
            nxt_r.lan_wan = !nxt_r.lan_rej && (nxt_r.tbl_hit
                            ? nxt_r.tbl_dst[1] : 1'b1);
        end

        // WAN protocol routing and bucket search
        case (r_ff.ws)
            WS_IDLE: begin
                if (wan_start_i && r_ff.wan_en) begin
                    if (!wan_ok_i) begin
                        nxt_r.wan_done = 1'b1;
                        nxt_r.wan_drop = 1'b1;
                        nxt_r.wan_lan = 1'b0;
                        nxt_r.wan_cpu = 1'b0;
                    end else if (wan_proto_i[PROTO_MSB]) begin
                        nxt_r.wan_done = 1'b1;
                        nxt_r.wan_drop = 1'b0;
                        nxt_r.wan_lan = 1'b0;
                        nxt_r.wan_cpu = 1'b1;
                    end else begin
                        nxt_r.hash = hash_f(wan_da_i);
                        nxt_r.slot = 3'h0;
                        nxt_r.ws = WS_SEARCH;
                        nxt_r.db_rd = 1'b1;
                        nxt_r.rd_pend = 1'b1;
                    end
                end
            end
            WS_SEARCH: begin
                nxt_r.rd_pend = 1'b0;
                if (!r_ff.rd_pend) begin
                    if (db_valid_i && db_addr_val_i == wan_da_i) begin
                        nxt_r.ws = WS_DONE;
                        nxt_r.wan_done = 1'b1;
                        nxt_r.wan_drop = 1'b0;
                        nxt_r.wan_lan = db_dst_i == SA_LAN
                                        || db_dst_i == SA_BOTH;
                        nxt_r.wan_cpu = db_dst_i == SA_CPU
                                        || db_dst_i == SA_BOTH;
                    end else if (r_ff.slot == 3'(BKT_DEPTH - 1)) begin
                        nxt_r.ws = WS_DONE;
                        nxt_r.wan_done = 1'b1;
                        nxt_r.wan_drop = 1'b0;
                        nxt_r.wan_lan = 1'b1;
                        nxt_r.wan_cpu = 1'b0;
                    end else begin
                        nxt_r.slot = r_ff.slot + 3'h1;
                        nxt_r.db_rd = 1'b1;
                        nxt_r.rd_pend = 1'b1;
                    end
                end
            end
            WS_DONE: nxt_r.ws = WS_IDLE;
            default: nxt_r.ws = WS_IDLE;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n) begin
            r_ff.rdata <= 16'h0000;
            r_ff.ctl <= '0;
            r_ff.val <= '0;
            r_ff.msk <= '0;
            r_ff.lan_en <= 1'b0;
            r_ff.wan_en <= 1'b0;
            r_ff.in_frame <= 1'b0;
            r_ff.wcnt <= 5'h00;
            r_ff.idx <= '0;
            r_ff.res <= '0;
            r_ff.tbl_dst <= 2'h0;
            r_ff.tbl_hit <= 1'b0;
            r_ff.lan_done <= 1'b0;
            r_ff.lan_cpu <= 1'b0;
            r_ff.lan_wan <= 1'b0;
            r_ff.lan_rej <= 1'b0;
            r_ff.ws <= WS_IDLE;
            r_ff.hash <= '0;
            r_ff.slot <= 3'h0;
            r_ff.db_rd <= 1'b0;
            r_ff.rd_pend <= 1'b0;
            r_ff.wan_done <= 1'b0;
            r_ff.wan_lan <= 1'b0;
            r_ff.wan_cpu <= 1'b0;
            r_ff.wan_drop <= 1'b0;
        end else begin
            r_ff.rdata <= nxt_r.rdata;
            r_ff.ctl <= nxt_r.ctl;
            r_ff.val <= nxt_r.val;
            r_ff.msk <= nxt_r.msk;
            r_ff.lan_en <= nxt_r.lan_en;
            r_ff.wan_en <= nxt_r.wan_en;
            r_ff.in_frame <= nxt_r.in_frame;
            r_ff.wcnt <= nxt_r.wcnt;
            r_ff.idx <= nxt_r.idx;
            r_ff.res <= nxt_r.res;
            r_ff.tbl_dst <= nxt_r.tbl_dst;
            r_ff.tbl_hit <= nxt_r.tbl_hit;
            r_ff.lan_done <= nxt_r.lan_done;
            r_ff.lan_cpu <= nxt_r.lan_cpu;
            r_ff.lan_wan <= nxt_r.lan_wan;
            r_ff.lan_rej <= nxt_r.lan_rej;
            r_ff.ws <= nxt_r.ws;
            r_ff.hash <= nxt_r.hash;
            r_ff.slot <= nxt_r.slot;
            r_ff.db_rd <= nxt_r.db_rd;
            r_ff.rd_pend <= nxt_r.rd_pend;
            r_ff.wan_done <= nxt_r.wan_done;
            r_ff.wan_lan <= nxt_r.wan_lan;
            r_ff.wan_cpu <= nxt_r.wan_cpu;
            r_ff.wan_drop <= nxt_r.wan_drop;
        end
    end

    assign reg_rdata_o  = r_ff.rdata;
    assign lan_done_o   = r_ff.lan_done;
    assign lan_to_cpu_o = r_ff.lan_cpu;
    assign lan_to_wan_o = r_ff.lan_wan;
    assign lan_reject_o = r_ff.lan_rej;
    assign db_rd_o      = r_ff.db_rd;
    assign db_addr_o    = {r_ff.hash, r_ff.slot};
    assign wan_done_o   = r_ff.wan_done;
    assign wan_to_lan_o = r_ff.wan_lan;
    assign wan_to_cpu_o = r_ff.wan_cpu;
    assign wan_drop_o   = r_ff.wan_drop;
endmodule
`default_nettype wire

// ==== shared/fpf_pkg.sv ====
// Constants and types for the frame pattern and protocol filter
`default_nettype none
package fpf_pkg;
    localparam int          ENTRIES    = 24;
    localparam int          STRINGS    = 8;
    localparam int          BUCKETS    = 1024;
    localparam int          BKT_DEPTH  = 8;
    localparam int          HASH_W     = 10;
    localparam int          ADDR_W     = 48;
    // Register offsets (word addresses on the 8-bit port)
    localparam logic [7:0]  REG_CTRL   = 8'h00;
    localparam logic [7:0]  REG_LSTAT  = 8'h01;
    localparam logic [7:0]  REG_WSTAT  = 8'h02;
    localparam logic [7:0]  REG_TBL    = 8'h40;
    localparam logic [7:0]  REG_TBL_END = 8'h88;
    localparam logic [1:0]  CTRL_RST   = 2'h3;
    // Control word fields
    localparam int          CW_EN      = 15;
    localparam int          CW_OFS_HI  = 14;
    localparam int          CW_OFS_LO  = 10;
    localparam int          CW_DST_HI  = 9;
    localparam int          CW_DST_LO  = 8;
    localparam int          CW_BEG     = 7;
    localparam int          CW_END     = 6;
    localparam int          CW_STR_HI  = 5;
    localparam int          CW_STR_LO  = 3;
    localparam int          CW_OP_HI   = 1;
    localparam int          CW_OP_LO   = 0;
    localparam logic [1:0]  OP_EQ      = 2'h0;
    localparam logic [1:0]  OP_LT      = 2'h1;
    localparam logic [1:0]  OP_GT      = 2'h2;
    localparam logic [1:0]  DST_REJECT = 2'h0;
    localparam logic [2:0]  SA_LAN     = 3'h0;
    localparam logic [2:0]  SA_CPU     = 3'h1;
    localparam logic [2:0]  SA_BOTH    = 3'h5;
    localparam logic [2:0]  SA_REJECT  = 3'h0;
    localparam int          PROTO_MSB  = 15;
    typedef enum {WS_IDLE, WS_HASH, WS_SEARCH, WS_DONE} fpf_wstate_t;
endpackage
`default_nettype wire

// ==== tb/fpf_assertions.sv ====
// Port-level property checks for the frame filter engine
`timescale 1ns/10ps
`default_nettype none
module fpf_assertions import fpf_pkg::*; (
    input wire logic        clk_i,
    input wire logic        nrst_i,
    input wire logic        lan_vld_i,
    input wire logic        lan_eof_i,
    input wire logic [2:0]  lan_sa_dst_i,
    input wire logic        lan_done_o,
    input wire logic        lan_to_cpu_o,
    input wire logic        lan_to_wan_o,
    input wire logic        lan_reject_o,
    input wire logic        wan_start_i,
    input wire logic        wan_ok_i,
    input wire logic [15:0] wan_proto_i,
    input wire logic [47:0] wan_da_i,
    input wire logic        db_rd_o,
    input wire logic [12:0] db_addr_o,
    input wire logic        db_valid_i,
    input wire logic [47:0] db_addr_val_i,
    input wire logic [2:0]  db_dst_i,
    input wire logic        wan_done_o,
    input wire logic        wan_to_lan_o,
    input wire logic        wan_to_cpu_o,
    input wire logic        wan_drop_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);

    function automatic logic [9:0] hsh(input logic [47:0] a);
        logic [55:0] x;
        x = {8'h00, a};
        for (int n = 0; n < 10; n++) hsh[n] = x[n] ^ x[n+10] ^ x[n+20] ^ x[n+30] ^ x[n+40];
    endfunction

    lan_done_cause_a: assert property (
        lan_done_o |-> $past(lan_vld_i && lan_eof_i)) else $error("lan done without end");
    sa_reject_a: assert property (
        lan_done_o && $past(lan_sa_dst_i) == SA_REJECT |-> lan_reject_o)
        else $error("lookup reject not honoured");
    reject_alone_a: assert property (
        lan_reject_o |-> !lan_to_cpu_o && !lan_to_wan_o) else $error("rejected frame routed");
    wan_drop_a: assert property (
        wan_done_o && wan_drop_o |-> !wan_to_lan_o && !wan_to_cpu_o) else $error("dropped frame routed");
    wan_ctrl_a: assert property (
        wan_done_o && $past(wan_start_i && wan_ok_i && wan_proto_i[PROTO_MSB])
        |-> wan_to_cpu_o && !wan_to_lan_o && !wan_drop_o) else $error("control frame misrouted");
    ctrl_no_read_a: assert property (
        wan_start_i && wan_proto_i[PROTO_MSB] |=> !db_rd_o) else $error("control frame looked up");
    hash_addr_a: assert property (
        db_rd_o |-> db_addr_o[12:3] == hsh(wan_da_i)) else $error("bucket hash wrong");
    slot_first_a: assert property (
        db_rd_o && !$past(db_rd_o, 2) |-> db_addr_o[2:0] == 3'h0) else $error("search not from slot 0");
    slot_step_a: assert property (
        db_rd_o && $past(db_rd_o, 2) |-> db_addr_o == $past(db_addr_o, 2) + 13'h1)
        else $error("slot not linear");
    slot_end_a: assert property (
        db_rd_o && db_addr_o[2:0] == 3'h7 |-> ##[1:3] wan_done_o) else $error("search past bucket end");
    hit_both_a: assert property (
        db_rd_o ##1 (db_valid_i && db_addr_val_i == wan_da_i && db_dst_i == SA_BOTH)
        |-> ##[1:2] (wan_done_o && wan_to_lan_o && wan_to_cpu_o)) else $error("both code misrouted");
endmodule

bind fpf_filter fpf_assertions u_chk (.clk_i(clk_i), .nrst_i(nrst_i),
    .lan_vld_i(lan_vld_i), .lan_eof_i(lan_eof_i), .lan_sa_dst_i(lan_sa_dst_i),
    .lan_done_o(lan_done_o), .lan_to_cpu_o(lan_to_cpu_o),
    .lan_to_wan_o(lan_to_wan_o), .lan_reject_o(lan_reject_o),
    .wan_start_i(wan_start_i), .wan_ok_i(wan_ok_i), .wan_proto_i(wan_proto_i),
    .wan_da_i(wan_da_i), .db_rd_o(db_rd_o), .db_addr_o(db_addr_o),
    .db_valid_i(db_valid_i), .db_addr_val_i(db_addr_val_i), .db_dst_i(db_dst_i),
    .wan_done_o(wan_done_o), .wan_to_lan_o(wan_to_lan_o),
    .wan_to_cpu_o(wan_to_cpu_o), .wan_drop_o(wan_drop_o));
`default_nettype wire

// ==== tb/fpf_db_model.sv ====
// Address database memory answering the engine's bucket reads
`timescale 1ns/10ps
`default_nettype none
module fpf_db_model (
    input  wire logic        clk_i,
    input  wire logic        rd_i,
    input  wire logic [12:0] addr_i,
    output logic             valid_o,
    output logic [47:0]      addr_val_o,
    output logic [2:0]       dst_o
);
    logic        vld [8192];
    logic [47:0] adr [8192];
    logic [2:0]  dst [8192];
    initial begin
        foreach (vld[i]) begin
            vld[i] = 1'b0;
            adr[i] = 48'h0;
            dst[i] = 3'h0;
        end
        valid_o    = 1'b0;
        addr_val_o = 48'h0;
        dst_o      = 3'h0;
    end
    always @(posedge clk_i) begin
        if (rd_i) begin
            valid_o    <= vld[addr_i];
            addr_val_o <= adr[addr_i];
            dst_o      <= dst[addr_i];
        end else begin
            // Answer lasts one cycle, then valid drops and the last value is inverted on each idle cycle
            valid_o    <= 1'b0;
            addr_val_o <= ~addr_val_o;
            dst_o      <= ~dst_o;
        end
    end
endmodule
`default_nettype wire

// ==== tb/testbench.sv ====
// Directed test bench for the frame filter engine
`timescale 1ns/10ps
`default_nettype none
module testbench import fpf_pkg::*;;
    localparam logic [47:0] DA = 48'h0123_4567_89ab;
    logic        clk_i = 1'b0, nrst_i = 1'b0;
    logic [7:0]  reg_addr_i = 8'h00;
    logic [15:0] reg_wdata_i = 16'h0, reg_rdata_o, lan_word_i = 16'h0;
    logic        reg_wr_i = 1'b0, reg_rd_i = 1'b0;
    logic        lan_vld_i = 1'b0, lan_sof_i = 1'b0, lan_eof_i = 1'b0;
    logic [2:0]  lan_sa_dst_i = 3'h0, db_dst_i;
    logic        lan_done_o, lan_to_cpu_o, lan_to_wan_o, lan_reject_o;
    logic        wan_start_i = 1'b0, wan_ok_i = 1'b0;
    logic [15:0] wan_proto_i = 16'h0;
    logic        db_rd_o, db_valid_i, wan_done_o, wan_to_lan_o, wan_to_cpu_o;
    logic        wan_drop_o;
    logic [12:0] db_addr_o;
    logic [47:0] db_addr_val_i;
    logic [9:0]  h;
    logic [2:0]  codes [4] = '{3'h0, 3'h1, 3'h5, 3'h2};
    logic [2:0]  expw [4] = '{3'h4, 3'h2, 3'h6, 3'h0};
    logic [2:0]  expl [4] = '{3'h1, 3'h4, 3'h2, 3'h6};
    int          fails = 0, n_checks = 0;

    fpf_filter u_dut (.clk_i(clk_i), .nrst_i(nrst_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o), .lan_vld_i(lan_vld_i), .lan_sof_i(lan_sof_i),
        .lan_eof_i(lan_eof_i), .lan_word_i(lan_word_i), .lan_sa_dst_i(lan_sa_dst_i),
        .lan_done_o(lan_done_o), .lan_to_cpu_o(lan_to_cpu_o),
        .lan_to_wan_o(lan_to_wan_o), .lan_reject_o(lan_reject_o),
        .wan_start_i(wan_start_i), .wan_ok_i(wan_ok_i), .wan_proto_i(wan_proto_i),
        .wan_da_i(DA), .db_rd_o(db_rd_o), .db_addr_o(db_addr_o),
        .db_valid_i(db_valid_i), .db_addr_val_i(db_addr_val_i), .db_dst_i(db_dst_i),
        .wan_done_o(wan_done_o), .wan_to_lan_o(wan_to_lan_o),
        .wan_to_cpu_o(wan_to_cpu_o), .wan_drop_o(wan_drop_o));
    fpf_db_model u_db (.clk_i(clk_i), .rd_i(db_rd_o), .addr_i(db_addr_o),
        .valid_o(db_valid_i), .addr_val_o(db_addr_val_i), .dst_o(db_dst_i));

    initial begin
        forever #25 clk_i = ~clk_i;
    end

    function automatic logic [9:0] hsh(input logic [47:0] a);
        logic [55:0] x;
        x = {8'h00, a};
        for (int n = 0; n < 10; n++) hsh[n] = x[n] ^ x[n+10] ^ x[n+20] ^ x[n+30] ^ x[n+40];
    endfunction
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic end_sim;
        $display("Checks %0d, mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk_i);
        reg_wr_i    <= 1'b1;
        reg_addr_i  <= a;
        reg_wdata_i <= d;
        @(posedge clk_i);
        reg_wr_i <= 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [15:0] e);
        @(posedge clk_i);
        reg_rd_i   <= 1'b1;
        reg_addr_i <= a;
        @(posedge clk_i);
        reg_rd_i <= 1'b0;
        #1 chk(reg_rdata_o, e);
    endtask
    task automatic put_entry(input int i, input logic [15:0] c, v, m);
        wr(REG_TBL + 8'(3 * i), c);
        wr(REG_TBL + 8'(3 * i + 1), v);
        wr(REG_TBL + 8'(3 * i + 2), m);
    endtask
    task automatic wait_done;
        for (int i = 0; i < 200; i++) begin
            #1;
            if (lan_done_o === 1'b1 || wan_done_o === 1'b1) return;
            @(posedge clk_i);
        end
        fails++;
        $display("CHECK FAILED at %0t: no completion", $time);
        end_sim;
    endtask
    // Four words with idle gaps; word 1 is fixed, words 2 and 3 zero
    task automatic lan_frame(input logic [15:0] w0, input logic [2:0] sa, e);
        for (int k = 0; k < 4; k++) begin
            @(posedge clk_i);
            lan_sa_dst_i <= sa;
            lan_vld_i  <= 1'b1;
            lan_sof_i  <= (k == 0);
            lan_eof_i  <= (k == 3);
            lan_word_i <= (k == 0) ? w0 : (k == 1) ? 16'h1234 : 16'h0000;
            @(posedge clk_i);
            lan_vld_i <= 1'b0;
            if (k < 3) repeat (3) @(posedge clk_i);
        end
        wait_done;
        chk({13'h0, lan_to_cpu_o, lan_to_wan_o, lan_reject_o}, {13'h0, e});
    endtask
    task automatic wan_frame(input logic ok, input logic [15:0] p, input logic [2:0] e);
        @(posedge clk_i);
        wan_start_i <= 1'b1;
        wan_ok_i    <= ok;
        wan_proto_i <= p;
        @(posedge clk_i);
        wan_start_i <= 1'b0;
        wait_done;
        chk({13'h0, wan_to_lan_o, wan_to_cpu_o, wan_drop_o}, {13'h0, e});
    endtask

    initial begin
        repeat (8) @(posedge clk_i);
        nrst_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        rd_chk(REG_CTRL, 16'h0000);
        put_entry(23, 16'h7c3f, 16'h5a5a, 16'ha5a5);
        rd_chk(REG_TBL + 8'd69, 16'h7c3f);
        rd_chk(REG_TBL + 8'd70, 16'h5a5a);
        rd_chk(REG_TBL + 8'd71, 16'ha5a5);
        wr(8'hff, 16'hffff);
        rd_chk(8'hff, 16'h0000);
        wr(REG_CTRL, 16'h0003);
        rd_chk(REG_CTRL, 16'h0003);
        // Offsets non-decreasing, one string only so no conflicts
        put_entry(0, 16'h8380, 16'hab00, 16'hff00);
        put_entry(1, 16'h0400, 16'hffff, 16'hffff);
        for (int k = 0; k < 4; k++) begin
            put_entry(2, 16'h8740 | 16'(k), 16'h0050, 16'h00f0);
            lan_frame(16'habcd, 3'h2, (k == 1) ? 3'h6 : 3'h2);
        end
        put_entry(2, 16'h8741, 16'h0050, 16'h00f0);
        lan_frame(16'h0bcd, 3'h2, 3'h2);
        lan_frame(16'habcd, 3'h0, 3'h1);
        for (int d = 0; d < 4; d++) begin
            put_entry(2, 16'h8441 | 16'(d << 8), 16'h0050, 16'h00f0);
            lan_frame(16'habcd, 3'h2, expl[d]);
        end
        // String 0 true, hit, both destinations, frame closed
        rd_chk(REG_LSTAT, 16'h010b);
        // Begin entry of string 1 at offset 1 must overwrite, not AND
        put_entry(2, 16'h87c9, 16'h0050, 16'h00f0);
        lan_frame(16'h0bcd, 3'h2, 3'h6);
        h = hsh(DA);
        u_db.vld[{h, 3'h0}] = 1'b1;
        u_db.adr[{h, 3'h0}] = DA ^ 48'h1;
        u_db.adr[{h, 3'h1}] = DA;
        u_db.vld[{h, 3'h2}] = 1'b1;
        u_db.adr[{h, 3'h2}] = DA;
        wan_frame(1'b0, 16'h0021, 3'h1);
        wan_frame(1'b1, 16'h8021, 3'h2);
        wan_frame(1'b1, 16'hc021, 3'h2);
        for (int c = 0; c < 4; c++) begin
            u_db.dst[{h, 3'h2}] = codes[c];
            wan_frame(1'b1, 16'h3fff, expw[c]);
        end
        u_db.vld[{h, 3'h2}] = 1'b0;
        wan_frame(1'b1, 16'h0800, 3'h4);
        rd_chk(REG_WSTAT, {6'h00, h});
        end_sim;
    end
endmodule
`default_nettype wire
